// ---- verilog/can_mode_defines.svh ----
// Register map, field positions, codes and reset values of the CAN mode control block
`ifndef CAN_MODE_DEFINES_SVH
`define CAN_MODE_DEFINES_SVH

`define CMC_ADDR_W        16
`define CMC_DATA_W        16
`define CMC_CTRL_ADDR     16'hFF90
`define CMC_RESET_VALUE   16'h0000
`define CMC_READ_IDLE     16'h0000

`define CMC_OPM_LSB       0
`define CMC_OPM_MSB       2
`define CMC_PSM_LSB       3
`define CMC_PSM_MSB       4
`define CMC_VALID_BIT     5
`define CMC_AL_BIT        6
`define CMC_ERR_COUNT_CLEAR_REQ_BIT     7
`define CMC_TX_ACTIVE_FLAG_BIT     8
`define CMC_RX_ACTIVE_FLAG_BIT     9
`define CMC_SET_OFS       8

`define CMC_OPM_INIT      3'h0
`define CMC_OPM_NORMAL    3'h1
`define CMC_OPM_ABT       3'h2
`define CMC_OPM_RXONLY    3'h3
`define CMC_OPM_SSHOT     3'h4
`define CMC_OPM_SELFTEST  3'h5

`define CMC_PSM_NONE      2'h0
`define CMC_PSM_SLEEP     2'h1
`define CMC_PSM_BAD       2'h2
`define CMC_PSM_STOP      2'h3

`endif

// ---- verilog/can_mode_pkg.sv ----
// Types shared by the CAN mode control block
package can_mode_pkg;
  typedef logic [2:0]  op_mode_t;
  typedef logic [1:0]  ps_mode_t;
  typedef logic [15:0] cmc_word_t;
endpackage : can_mode_pkg

// ---- verilog/can_mode_control_status.sv ----
// CAN mode control and status register with mode sequencing
// Operation
// - Rx busy set on rx SOF or arbitration loss
// - Rx busy cleared at IFS bit2 or init
// - Tx busy set on tx SOF or error flag
// - Tx busy cleared: bus-off, arb loss, IFS, init
// - Clear request in init resets error counters
// - Clear request drops itself after counters cleared
// - Clear request settable only in init mode
// - Sleep/stop freeze op mode and clear request
// - Arbitration-loss retry bit acts in single-shot only
// - Valid flag set by any valid frame
// - Receive-only mode never drives acknowledge
// - Power-save codes 00 none, 01 sleep, 11 stop
// - Stop entered and left only via sleep
// - Sleep request pends until bus idle
// - Op mode codes 000 to 101 defined, 110 and 111 accepted too
// - Clear request set only when set and clear
// - Set/clear pairs drive retry, power, op bits
// - Valid clear bit one clears the flag
// - Sixteen-bit register, resets to all zeros
`include "can_mode_defines.svh"
`timescale 1ns/1ns
`default_nettype none

module can_mode_control_status
  import can_mode_pkg::*;
(
  input  wire logic                    i_clk_sys,           // System clock, 100 MHz
  input  wire logic                    i_srst,              // Synchronous reset, active high
  input  wire logic [`CMC_ADDR_W-1:0]  i_addr,              // Register address
  input  wire logic [`CMC_DATA_W-1:0]  i_wdata,             // Write data
  input  wire logic                    i_wr,                // Write strobe
  input  wire logic                    i_rd,                // Read strobe
  output logic      [`CMC_DATA_W-1:0]  o_rdata,             // Read data, cycle after read strobe
  input  wire logic                    i_rx_sof,            // SOF of a receive frame seen
  input  wire logic                    i_tx_sof,            // SOF of a transmit frame seen
  input  wire logic                    i_arb_lost,          // Arbitration lost during transmit
  input  wire logic                    i_tx_err_flag,       // First error flag bit in transmit frame
  input  wire logic                    i_bus_off_enter,     // Entering bus-off state
  input  wire logic                    i_ifs_bit1,          // First interframe-space bit
  input  wire logic                    i_ifs_bit2_rec,      // Recessive at second IFS bit
  input  wire logic                    i_bus_idle,          // Bus is idle
  input  wire logic                    i_valid_frame,       // Valid frame received
  output logic      [2:0]              o_op_mode,           // Operation mode in effect
  output logic      [1:0]              o_power_save,        // Power-save mode in effect
  output logic                         o_err_count_clear,   // Reset error counter and state info
  output logic                         o_arb_retry_en,      // Retry after arbitration loss
  output logic                         o_ack_enable         // Acknowledge bits may be driven
);

  // Set/clear pair update of one control bit
  function automatic logic setclr(input logic cur, input logic set_b, input logic clr_b);
    logic res;
    res = cur;
    if (set_b && !clr_b)
      res = 1'b1;
    else if (!set_b && clr_b)
      res = 1'b0;
    return res;
  endfunction : setclr

  op_mode_t  op_req_q;         // Requested operation mode
  op_mode_t  op_mode_q;        // Operation mode in effect
  ps_mode_t  ps_req_q;         // Requested power-save mode
  ps_mode_t  ps_mode_q;        // Power-save mode in effect
  logic      err_count_clear_req_q;          // Error counter clear request
  logic      al_q;             // Retry after arbitration loss
  logic      valid_q;          // Valid frame seen
  logic      rx_busy_q;        // Reception in progress
  logic      tx_busy_q;        // Transmission in progress
  logic      [`CMC_DATA_W-1:0] rdata_q;

  logic      wr_hit;
  logic      rd_hit;
  logic      [7:0] set_b;
  logic      [7:0] clr_b;
  logic      in_init;
  logic      in_pwr_save;
  logic      init_at_ifs;
  op_mode_t  op_req_d;
  ps_mode_t  ps_req_d;
  logic      err_count_clear_req_set;
  cmc_word_t status_word;

  // Address decode; the upper byte carries set bits, the lower byte clear bits
  assign wr_hit      = i_wr && (i_addr == `CMC_CTRL_ADDR);
  assign rd_hit      = i_rd && (i_addr == `CMC_CTRL_ADDR);
  assign set_b       = i_wdata[`CMC_DATA_W-1:`CMC_SET_OFS];
  assign clr_b       = i_wdata[`CMC_SET_OFS-1:0];
  assign in_init     = (op_mode_q == `CMC_OPM_INIT);
  assign in_pwr_save = (ps_mode_q == `CMC_PSM_SLEEP) || (ps_mode_q == `CMC_PSM_STOP);
  // Pending init request that takes effect at the first IFS bit
  assign init_at_ifs = (op_req_q == `CMC_OPM_INIT) && !in_init && i_ifs_bit1;

  // Next requested op mode; frozen while a power-save mode holds
  always_comb
  begin
    op_req_d = op_req_q;
    if (wr_hit && !in_pwr_save)
    begin
      for (int i = `CMC_OPM_LSB; i <= `CMC_OPM_MSB; i++)
        op_req_d[i] = setclr(op_req_q[i], set_b[i], clr_b[i]);
    end
  end

  // Next requested power-save mode; illegal or direct stop moves are dropped
  always_comb
  begin
    ps_req_d = ps_req_q;
    if (wr_hit)
    begin
      ps_req_d[0] = setclr(ps_req_q[0], set_b[`CMC_PSM_LSB], clr_b[`CMC_PSM_LSB]);
      ps_req_d[1] = setclr(ps_req_q[1], set_b[`CMC_PSM_MSB], clr_b[`CMC_PSM_MSB]);
      if (ps_req_d == `CMC_PSM_BAD)
        ps_req_d = ps_req_q;
      else if (ps_req_d == `CMC_PSM_STOP && ps_mode_q != `CMC_PSM_SLEEP && ps_mode_q != `CMC_PSM_STOP)
        ps_req_d = ps_req_q;
      else if (ps_mode_q == `CMC_PSM_STOP && ps_req_d == `CMC_PSM_NONE)
        ps_req_d = ps_req_q;
    end
  end

  // Clear request accepted only with both pair bits, in init, outside power save
  assign err_count_clear_req_set = wr_hit && set_b[`CMC_ERR_COUNT_CLEAR_REQ_BIT] && clr_b[`CMC_ERR_COUNT_CLEAR_REQ_BIT]
                     && in_init && !in_pwr_save;

  // Requested op mode register
  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
      op_req_q <= `CMC_OPM_INIT;
    else
      op_req_q <= op_req_d;
  end

  // Effective op mode; init waits for a frame boundary, leaving init waits for the counter clear
  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
      op_mode_q <= `CMC_OPM_INIT;
    else if (op_req_q != op_mode_q)
    begin
      if (op_req_q == `CMC_OPM_INIT)
      begin
        if (i_ifs_bit1 || i_bus_idle)
          op_mode_q <= op_req_q;
      end
      else if (!in_init || !err_count_clear_req_q)
        op_mode_q <= op_req_q;
    end
  end

  // Requested power-save mode register
  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
      ps_req_q <= `CMC_PSM_NONE;
    else
      ps_req_q <= ps_req_d;
  end

  // Effective power-save mode; sleep entry pends for bus idle, other steps are direct
  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
      ps_mode_q <= `CMC_PSM_NONE;
    else if (ps_req_q != ps_mode_q)
    begin
      if (ps_mode_q == `CMC_PSM_NONE)
      begin
        if (ps_req_q == `CMC_PSM_SLEEP && i_bus_idle)
          ps_mode_q <= `CMC_PSM_SLEEP;
      end
      else if (ps_mode_q == `CMC_PSM_SLEEP)
        ps_mode_q <= ps_req_q;
      else if (ps_req_q == `CMC_PSM_SLEEP)
        ps_mode_q <= `CMC_PSM_SLEEP;
    end
  end

  // Clear request; a new set wins over the automatic drop
  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
      err_count_clear_req_q <= 1'b0;
    else if (err_count_clear_req_set)
      err_count_clear_req_q <= 1'b1;
    else if (err_count_clear_req_q && in_init)
      err_count_clear_req_q <= 1'b0;
  end

  // Counters are cleared in the cycle the request stands in init
  assign o_err_count_clear = err_count_clear_req_q && in_init;

  // Retry policy bit
  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
      al_q <= 1'b0;
    else if (wr_hit)
      al_q <= setclr(al_q, set_b[`CMC_AL_BIT], clr_b[`CMC_AL_BIT]);
  end

  // Outside single-shot mode frames are always retried
  assign o_arb_retry_en = (op_mode_q == `CMC_OPM_SSHOT) ? al_q : 1'b1;

  // Valid flag; a frame in the clearing cycle still sets it
  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
      valid_q <= 1'b0;
    else if (i_valid_frame)
      valid_q <= 1'b1;
    else if (wr_hit && clr_b[`CMC_VALID_BIT])
      valid_q <= 1'b0;
  end

  // Reception status
  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
      rx_busy_q <= 1'b0;
    else if (i_rx_sof || i_arb_lost)
      rx_busy_q <= 1'b1;
    else if (i_ifs_bit2_rec || init_at_ifs)
      rx_busy_q <= 1'b0;
  end

  // Transmission status; arbitration loss hands the frame over to reception
  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
      tx_busy_q <= 1'b0;
    else if (i_bus_off_enter || i_arb_lost)
      tx_busy_q <= 1'b0;
    else if (i_tx_sof || i_tx_err_flag)
      tx_busy_q <= 1'b1;
    else if (i_ifs_bit2_rec || init_at_ifs)
      tx_busy_q <= 1'b0;
  end

  // Acknowledge is suppressed in receive-only mode and while not operating
  assign o_ack_enable = (op_mode_q != `CMC_OPM_RXONLY) && !in_init;

  // Read view: effective modes, upper bits zero
  always_comb
  begin
    status_word                                = `CMC_READ_IDLE;
    status_word[`CMC_OPM_MSB:`CMC_OPM_LSB]     = op_mode_q;
    status_word[`CMC_PSM_MSB:`CMC_PSM_LSB]     = ps_mode_q;
    status_word[`CMC_VALID_BIT]                = valid_q;
    status_word[`CMC_AL_BIT]                   = al_q;
    status_word[`CMC_ERR_COUNT_CLEAR_REQ_BIT]                = err_count_clear_req_q;
    status_word[`CMC_TX_ACTIVE_FLAG_BIT]                = tx_busy_q;
    status_word[`CMC_RX_ACTIVE_FLAG_BIT]                = rx_busy_q;
  end

  // Read data stands only in the cycle after the strobe; unmapped reads return zero
  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
      rdata_q <= `CMC_RESET_VALUE;
    else if (rd_hit)
      rdata_q <= status_word;
    else
      rdata_q <= `CMC_READ_IDLE;
  end

  assign o_rdata      = rdata_q;
  assign o_op_mode    = op_mode_q;
  assign o_power_save = ps_mode_q;

  // Checks
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_srst);

  sequence s_set_pair_al;
    wr_hit && set_b[`CMC_AL_BIT] && !clr_b[`CMC_AL_BIT];
  endsequence

  sequence s_sleep_entry;
    (ps_mode_q == `CMC_PSM_NONE) ##1 (ps_mode_q == `CMC_PSM_SLEEP);
  endsequence

  a_rx_busy_set: assert property ((i_rx_sof || i_arb_lost) |=> rx_busy_q)
    else $error("rx busy not set");

  a_rx_busy_clear: assert property (
    (i_ifs_bit2_rec && !i_rx_sof && !i_arb_lost) |=> !rx_busy_q)
    else $error("rx busy not cleared");

  a_tx_busy_set: assert property (
    ((i_tx_sof || i_tx_err_flag) && !i_bus_off_enter && !i_arb_lost) |=> tx_busy_q)
    else $error("tx busy not set");

  a_tx_busy_clear: assert property ((i_bus_off_enter || i_arb_lost) |=> !tx_busy_q)
    else $error("tx busy not cleared");

  a_err_clear_init: assert property (o_err_count_clear |-> (in_init && err_count_clear_req_q) ##1 !err_count_clear_req_q [*1]
                                     or (o_err_count_clear ##1 err_count_clear_req_q && $past(err_count_clear_req_set)))
    else $error("error clear outside init");

  a_err_count_clear_req_auto_drop: assert property ((err_count_clear_req_q && in_init && !err_count_clear_req_set) |=> !err_count_clear_req_q)
    else $error("clear request not dropped");

  a_err_count_clear_req_init_only: assert property ($rose(err_count_clear_req_q) |-> $past(in_init) && $past(wr_hit))
    else $error("clear request set outside init");

  a_mode_frozen: assert property ((wr_hit && in_pwr_save) |=> $stable(op_req_q))
    else $error("op mode written in power save");

  a_retry_single_shot: assert property (
    (op_mode_q != `CMC_OPM_SSHOT) |-> o_arb_retry_en)
    else $error("retry policy applied outside single shot");

  a_valid_set: assert property (i_valid_frame |=> valid_q)
    else $error("valid frame lost");

  a_ack_rx_only: assert property ((op_mode_q == `CMC_OPM_RXONLY) |-> !o_ack_enable)
    else $error("ack enabled in receive only");

  a_ps_legal: assert property (ps_mode_q != `CMC_PSM_BAD && ps_req_q != `CMC_PSM_BAD)
    else $error("illegal power save code");

  a_stop_via_sleep: assert property (
    ($changed(ps_mode_q) && (ps_mode_q == `CMC_PSM_STOP || $past(ps_mode_q) == `CMC_PSM_STOP))
    |-> ($past(ps_mode_q) == `CMC_PSM_SLEEP || ps_mode_q == `CMC_PSM_SLEEP))
    else $error("direct stop transition");

  a_sleep_on_idle: assert property (s_sleep_entry |-> $past(i_bus_idle))
    else $error("sleep entered while bus busy");

  a_op_code_legal: assert property ((op_req_q == op_mode_q) |-> op_mode_q <= `CMC_OPM_SELFTEST
                                    || $past(op_req_q) > `CMC_OPM_SELFTEST)
    else $error("op mode code not from request");

  a_err_count_clear_req_pair: assert property (
    (wr_hit && !(set_b[`CMC_ERR_COUNT_CLEAR_REQ_BIT] && clr_b[`CMC_ERR_COUNT_CLEAR_REQ_BIT]) && !err_count_clear_req_q) |=> !err_count_clear_req_q)
    else $error("clear request set without pair");

  a_al_set_pair: assert property (s_set_pair_al |=> al_q)
    else $error("retry bit not set");

  a_valid_clear: assert property (
    (wr_hit && clr_b[`CMC_VALID_BIT] && !i_valid_frame) |=> !valid_q)
    else $error("valid flag not cleared");

  a_read_timing: assert property (rd_hit |=> o_rdata == $past(status_word) ##1
                                  (o_rdata == `CMC_READ_IDLE || $past(rd_hit)))
    else $error("read data timing wrong");

  a_reset_zero: assert property (@(posedge i_clk_sys) disable iff (1'b0)
    i_srst |=> (op_mode_q == `CMC_OPM_INIT && ps_mode_q == `CMC_PSM_NONE
               && !err_count_clear_req_q && !al_q && !valid_q && !rx_busy_q && !tx_busy_q))
    else $error("reset state not zero");

endmodule : can_mode_control_status

`default_nettype wire

// ---- bench/can_bus_node_model.sv ----
// Behavioural model of the other CAN nodes, seen as protocol events
`timescale 1ns/1ns
`default_nettype none

module can_bus_node_model
(
  input  wire logic i_clk_sys,       // System clock
  output logic      o_rx_sof,        // Incoming frame start
  output logic      o_tx_sof,        // Own frame start
  output logic      o_arb_lost,      // Arbitration lost
  output logic      o_tx_err_flag,   // Error flag in own frame
  output logic      o_bus_off_enter, // Bus-off entry
  output logic      o_ifs_bit1,      // First IFS bit
  output logic      o_ifs_bit2_rec,  // Recessive second IFS bit
  output logic      o_bus_idle,      // Bus idle level
  output logic      o_valid_frame    // Valid frame seen
);
  logic [7:0] ev_q   = 8'h00;
  logic       idle_q = 1'b0;

  // Busy bus by default, so pending requests really have to wait
  assign {o_valid_frame, o_ifs_bit2_rec, o_ifs_bit1, o_bus_off_enter,
          o_tx_err_flag, o_arb_lost, o_tx_sof, o_rx_sof} = ev_q;
  assign o_bus_idle = idle_q;

  // One-cycle event after gap cycles; gap 0 answers promptly
  task automatic pulse(input int k, input int gap);
    repeat (gap) @(posedge i_clk_sys);
    @(posedge i_clk_sys);
    ev_q <= 8'h01 << k;
    @(posedge i_clk_sys);
    ev_q <= 8'h00;
  endtask : pulse

  // Bus idle level changes only at an edge
  task automatic set_idle(input logic v);
    @(posedge i_clk_sys);
    idle_q <= v;
  endtask : set_idle
endmodule : can_bus_node_model
`default_nettype wire

// ---- bench/test_can_mode_control_status.sv ----
// Self-checking bench for the CAN mode control and status register
`include "can_mode_defines.svh"
`timescale 1ns/1ns
`default_nettype none

module test_can_mode_control_status;
  localparam logic [15:0] A = `CMC_CTRL_ADDR;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic [15:0] addr = 16'h0000;
  logic [15:0] wdata = 16'h0000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [15:0] rdata;
  logic        rxs, txs, arb, txe, boff, ifs1, ifs2, idle, vld;
  logic [2:0]  op;
  logic [1:0]  ps;
  logic        clr, rty, ack;
  int          bad_count = 0;
  int          checked = 0;

  // 100 MHz clock
  initial
  begin
    forever #5 clk = ~clk;
  end

  can_mode_control_status i_dut (.i_clk_sys(clk), .i_srst(srst), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_rx_sof(rxs), .i_tx_sof(txs), .i_arb_lost(arb),
    .i_tx_err_flag(txe), .i_bus_off_enter(boff), .i_ifs_bit1(ifs1), .i_ifs_bit2_rec(ifs2),
    .i_bus_idle(idle), .i_valid_frame(vld), .o_op_mode(op), .o_power_save(ps),
    .o_err_count_clear(clr), .o_arb_retry_en(rty), .o_ack_enable(ack));

  can_bus_node_model i_peer (.i_clk_sys(clk), .o_rx_sof(rxs), .o_tx_sof(txs), .o_arb_lost(arb),
    .o_tx_err_flag(txe), .o_bus_off_enter(boff), .o_ifs_bit1(ifs1), .o_ifs_bit2_rec(ifs2),
    .o_bus_idle(idle), .o_valid_frame(vld));

  // Compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Closing report, also reached when a wait runs out
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : print_verdict

  // Bus write, strobe high for one sampling edge
  task automatic wr_reg(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  // Bus read; data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [15:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rd_reg

  // Read the control register and compare the masked fields
  task automatic expect_reg(input logic [15:0] mask, input logic [15:0] exp);
    logic [15:0] d;
    rd_reg(A, d);
    check(d & mask, exp);
  endtask : expect_reg

  // Bounded wait for the modes in effect; mode changes may lag the write
  task automatic wait_mode(input logic [2:0] o, input logic [1:0] p);
    #1;
    for (int n = 0; n < 20; n++)
    begin
      if (op === o && ps === p)
        break;
      @(posedge clk);
      #1;
    end
    check({11'h000, ps, op}, {11'h000, p, o});
    // A wait that ran out ends the run at the closing report
    if (op !== o || ps !== p)
      print_verdict();
  endtask : wait_mode

  // A refused request must leave the modes as they are
  task automatic hold_mode(input logic [2:0] o, input logic [1:0] p);
    repeat (4) @(posedge clk);
    wait_mode(o, p);
  endtask : hold_mode

  task automatic s_reset;
    expect_reg(16'hFFFF, `CMC_RESET_VALUE);
    check({13'h0000, clr, rty, ack}, 16'h0002);
  endtask : s_reset

  // Operation modes 001 to 101, then retry policy and refused pairs
  task automatic s_opmodes;
    logic [2:0] m;
    logic [15:0] r;
    for (int c = 1; c < 6; c++)
    begin
      m = 3'(c);
      wr_reg(A, {5'h00, m, 5'h00, ~m});
      wait_mode(m, 2'h0);
      check({13'h0000, clr, rty, ack}, {13'h0000, 1'b0, m != 3'h4, m != 3'h3});
    end
    wr_reg(A, 16'h0403);
    wr_reg(A, 16'h4000);
    #1 check({15'h0000, rty}, 16'h0001);
    wr_reg(A, 16'h4040);
    expect_reg(16'h0047, 16'h0044);
    wr_reg(A, 16'h0040);
    #1 check({15'h0000, rty}, 16'h0000);
    wr_reg(A, 16'h0707);
    hold_mode(3'h4, 2'h0);
    wr_reg(A, 16'h0106);
    wait_mode(3'h1, 2'h0);
    check({15'h0000, rty}, 16'h0001);
    wr_reg(16'hFF92, 16'h0205);
    expect_reg(16'h0007, 16'h0001);
    rd_reg(16'hFF92, r);
    check(r, 16'h0000);
  endtask : s_opmodes

  // Clear request outside and inside initialization
  task automatic s_clear_req;
    wr_reg(A, 16'h8080);
    #1 check({15'h0000, clr}, 16'h0000);
    expect_reg(16'h0080, 16'h0000);
    i_peer.pulse(0, 0);
    i_peer.pulse(1, 1);
    expect_reg(16'h0300, 16'h0300);
    wr_reg(A, 16'h0007);
    hold_mode(3'h1, 2'h0);
    i_peer.pulse(5, 2);
    wait_mode(3'h0, 2'h0);
    expect_reg(16'h0300, 16'h0000);
    wr_reg(A, 16'h8000);
    #1 check({15'h0000, clr}, 16'h0000);
    wr_reg(A, 16'h8080);
    #1 check({15'h0000, clr}, 16'h0001);
    @(posedge clk);
    #1 check({15'h0000, clr}, 16'h0000);
    expect_reg(16'h0080, 16'h0000);
    wr_reg(A, 16'h0020);
    wr_reg(A, 16'h8186);
    #1 check({15'h0000, clr}, 16'h0001);
    wait_mode(3'h1, 2'h0);
  endtask : s_clear_req

  // Activity flags against tx SOF, arbitration loss, error flag, bus-off and IFS bit2 events
  task automatic s_status;
    i_peer.pulse(1, 0);
    i_peer.pulse(2, 0);
    expect_reg(16'h0300, 16'h0200);
    i_peer.pulse(6, 3);
    expect_reg(16'h0300, 16'h0000);
    i_peer.pulse(3, 0);
    expect_reg(16'h0300, 16'h0100);
    i_peer.pulse(4, 0);
    expect_reg(16'h0300, 16'h0000);
    i_peer.pulse(1, 0);
    i_peer.pulse(6, 0);
    expect_reg(16'h0300, 16'h0000);
  endtask : s_status

  // Valid flag: set by a frame, kept by other writes, cleared by polling
  task automatic s_valid;
    logic [15:0] d;
    i_peer.pulse(7, 0);
    wr_reg(A, 16'h2000);
    wr_reg(A, 16'h0000);
    expect_reg(16'h0020, 16'h0020);
    for (int n = 0; n < 4; n++)
    begin
      wr_reg(A, 16'h0020);
      rd_reg(A, d);
      if (d[5] === 1'b0)
        break;
    end
    check(d & 16'h0020, 16'h0000);
  endtask : s_valid

  // Power-save requests, pending sleep and forbidden steps
  task automatic s_power;
    wr_reg(A, 16'h0810);
    hold_mode(3'h1, 2'h0);
    wr_reg(A, 16'h0018);
    i_peer.set_idle(1'b1);
    hold_mode(3'h1, 2'h0);
    wr_reg(A, 16'h0810);
    wait_mode(3'h1, 2'h1);
    wr_reg(A, 16'h0205);
    wr_reg(A, 16'h1008);
    hold_mode(3'h1, 2'h1);
    wr_reg(A, 16'h1800);
    wait_mode(3'h1, 2'h3);
    wr_reg(A, 16'h0018);
    hold_mode(3'h1, 2'h3);
    wr_reg(A, 16'h0810);
    wait_mode(3'h1, 2'h1);
    wr_reg(A, 16'h0018);
    wait_mode(3'h1, 2'h0);
    wr_reg(A, 16'h1800);
    hold_mode(3'h1, 2'h0);
  endtask : s_power

  // Reset for four cycles, then every scenario in turn
  initial
  begin
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    s_reset();
    s_opmodes();
    s_clear_req();
    s_status();
    s_valid();
    s_power();
    print_verdict();
  end
endmodule : test_can_mode_control_status
`default_nettype wire
